// ### common/gpage_params.svh
/*
 * constants of the 1-gbyte entry decoder: entry fields, memory types, control map.
 * assumes: included by bare name.
 */
`ifndef GPAGE_PARAMS_SVH
`define GPAGE_PARAMS_SVH

// ----------------------------------------------------------------------------
// entry layout
// ----------------------------------------------------------------------------
`define ENTRY_W            64
`define HOST_ADDR_W        46
`define EXEC_DENY_POS      63
`define RSVD_HI_POS        51
`define FRAME_LO_POS       30
`define RSVD_MID_HI_POS    29
`define RSVD_MID_LO_POS    13
`define ATTR_IDX_POS       12
`define EXT_ACC_POS        10
`define GLOBAL_POS         8
`define PAGE_SIZE_POS      7
`define DIRTY_POS          6
`define ACCESSED_POS       5
`define CACHE_DIS_POS      4
`define WRITE_THRU_POS     3
`define USER_POS           2
`define WRITE_POS          1
`define PRESENT_POS        0

// ----------------------------------------------------------------------------
// memory-type codes
// ----------------------------------------------------------------------------
`define MTYPE_W            3
`define MTYPE_DEFAULT      3'h0

// ----------------------------------------------------------------------------
// control port map
// ----------------------------------------------------------------------------
`define ADDR_W             4
`define DATA_W             32
`define REG_CTRL           4'h0
`define REG_STATUS         4'h4
`define REG_COUNT          4'h8
`define CTRL_W             7
`define CTRL_RESET         7'h00
`define CTRL_NOEX_POS      0
`define CTRL_NEST_POS      1
`define CTRL_GLOB_POS      2
`define CTRL_WPROT_POS     3
`define CTRL_TRACK_POS     4
`define CTRL_SUPP_POS      5
`define CTRL_COH_POS       6
`define CNT_W              16
`define CNT_ONE            16'h0001
`define ZERO32             32'h0000_0000

`endif

// ### common/gpage_pkg.sv
/*
 * types shared by the entry decoder and its helpers.
 * assumes: gpage_params.svh is on the include path.
 */
`include "gpage_params.svh"

package gpage_pkg;
    // decode outcome classes, one-hot
    typedef enum logic [3:0] {
        OUT_OK     = 4'b0001,
        OUT_NOTPRS = 4'b0010,
        OUT_DIR    = 4'b0100,
        OUT_RSVD   = 4'b1000
    } outcome_e;

    // walk state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } walk_e;

    typedef logic [`MTYPE_W-1:0]     mtype_t;
    typedef logic [`HOST_ADDR_W-1:0] haddr_t;
endpackage : gpage_pkg

// ### rtl/gpage_mtype.sv
/*
 * memory-type selector: turns the three attribute bits into a memory-type index.
 * assumes: purely combinational, used inside the entry decoder.
 */
`timescale 1ns/10ps
`include "gpage_params.svh"

module gpage_mtype (
    input  wire logic            coherent_in,     // requester in processor coherency domain
    input  wire logic            attr_idx_in,     // attribute index bit
    input  wire logic            cache_dis_in,    // cache disable bit
    input  wire logic            write_thru_in,   // write-through bit
    output gpage_pkg::mtype_t    mtype_out        // selected memory-type index
);
    import gpage_pkg::*;

    // ------------------------------------------------------------------------
    // selection
    // ------------------------------------------------------------------------
    // other requesters see the default type, the bits have no influence
    always_comb begin
        if (coherent_in) begin
            mtype_out = {attr_idx_in, cache_dis_in, write_thru_in};
        end else begin
            mtype_out = `MTYPE_DEFAULT;
        end
    end
endmodule : gpage_mtype

// ### rtl/gpage_perm.sv
/*
 * permission checker: privilege, write and execute checks of a 1-gbyte entry.
 * assumes: purely combinational, used inside the entry decoder.
 */
`timescale 1ns/10ps
`include "gpage_params.svh"

module gpage_perm (
    input  wire logic  user_ok_in,       // entry user bit
    input  wire logic  write_ok_in,      // entry write bit
    input  wire logic  exec_deny_in,     // entry execute-deny bit
    input  wire logic  no_exec_en_in,    // no-execute enable from context
    input  wire logic  wr_prot_en_in,    // write-protect enable from context
    input  wire logic  req_user_in,      // request carries user privilege
    input  wire logic  req_write_in,     // request seeks write
    input  wire logic  req_exec_in,      // request seeks execute
    output logic       deny_out          // any check failed
);
    import gpage_pkg::*;

    logic deny_user;  // user access refused
    logic deny_write; // write refused
    logic deny_exec;  // execute refused

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    always_comb begin
        deny_user  = req_user_in && !user_ok_in;
        deny_write = req_write_in && !write_ok_in
                     && (req_user_in || wr_prot_en_in);
        deny_exec  = req_exec_in && no_exec_en_in && exec_deny_in;
        deny_out   = deny_user || deny_write || deny_exec;
    end
endmodule : gpage_perm

// ### rtl/gpage_decode.sv
/*
 * 1-gbyte paging entry decoder: result and updated entry stand one cycle after a
 * request; context controls sit in a small register file on a strobe port.
 * assumes: one clock; the page walker stores the entry while writeback_out is high.
 */
// The strobed register port and the address map are this design's own decisions.
// Contract
// - execute denied when no-exec enabled and bit63
// - frame base taken from bits 45 to 30
// - nested enable marks frame as guest physical
// - coherent requesters get type from bits 12,4,3
// - bit 10 set on use when tracking enabled
// - bit 8 marks global when global enabled
// - bit 7 clear means directory, not page
// - bit 6 set after granted write request
// - bit 5 set when entry used
// - bit 2 clear denies user requests
// - bit 1 clear denies user, protected supervisor writes
// - present bit 0 required for valid page
// - extended accessed ignored without capability support
`timescale 1ns/10ps
`include "gpage_params.svh"

module gpage_decode (
    input  wire logic                clk_in,        // 200 mhz clock
    input  wire logic                reset_in,      // async reset, high
    // request
    input  wire logic                req_valid_in,  // entry presented
    input  wire logic [`ENTRY_W-1:0] entry_in,      // fetched entry
    input  wire logic                req_user_in,   // user privilege
    input  wire logic                req_write_in,  // write request
    input  wire logic                req_exec_in,   // execute request
    // control port
    input  wire logic [`ADDR_W-1:0]  reg_addr_in,   // register address
    input  wire logic [`DATA_W-1:0]  reg_wdata_in,  // write data
    input  wire logic                reg_write_in,  // write strobe
    input  wire logic                reg_read_in,   // read strobe
    output logic [`DATA_W-1:0]       reg_rdata_out, // read data
    // result
    output logic                     done_out,      // result valid pulse
    output logic                     granted_out,   // translation granted
    output logic                     fault_out,     // not present/reserved
    output logic                     perm_deny_out, // permission refused
    output logic                     is_dir_out,    // entry is a directory
    output gpage_pkg::haddr_t        frame_out,     // 1-gbyte frame base
    output logic                     frame_gpa_out, // frame needs 2nd stage
    output gpage_pkg::mtype_t        mtype_out,     // memory type index
    output logic                     global_out,    // translation global
    output logic [`ENTRY_W-1:0]      entry_upd_out, // entry with flags set
    output logic                     writeback_out  // entry must be stored
);
    import gpage_pkg::*;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // field test on a control word
    function automatic logic ctl_bit(input logic [`CTRL_W-1:0] c, input int pos);
        ctl_bit = c[pos];
    endfunction : ctl_bit

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [`CTRL_W-1:0]    ctrl_q;         // context controls
    logic [`CNT_W-1:0]     count_q;        // granted translations
    outcome_e              last_q;         // last outcome
    walk_e                 state_q;        // done tracker
    logic                  rsvd_bad;       // reserved bits nonzero
    logic                  present;        // entry present
    logic                  page_map;       // maps a page
    logic                  deny;           // permission fail
    logic                  ok;             // grant
    logic                  ext_track;      // extended accessed in use
    mtype_t                mtype;          // memory type
    logic [`ENTRY_W-1:0]   upd;            // updated entry
    outcome_e              outcome;        // this request's class

    // ------------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------------
    gpage_mtype u_mtype (
        .coherent_in   (ctl_bit(ctrl_q, `CTRL_COH_POS)),
        .attr_idx_in   (entry_in[`ATTR_IDX_POS]),
        .cache_dis_in  (entry_in[`CACHE_DIS_POS]),
        .write_thru_in (entry_in[`WRITE_THRU_POS]),
        .mtype_out     (mtype)
    );

    gpage_perm u_perm (
        .user_ok_in    (entry_in[`USER_POS]),
        .write_ok_in   (entry_in[`WRITE_POS]),
        .exec_deny_in  (entry_in[`EXEC_DENY_POS]),
        .no_exec_en_in (ctl_bit(ctrl_q, `CTRL_NOEX_POS)),
        .wr_prot_en_in (ctl_bit(ctrl_q, `CTRL_WPROT_POS)),
        .req_user_in   (req_user_in),
        .req_write_in  (req_write_in),
        .req_exec_in   (req_exec_in),
        .deny_out      (deny)
    );

    // ------------------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------------------
    // bits 62:52, 11 and 9 are never looked at here
    always_comb begin
        present  = entry_in[`PRESENT_POS];
        page_map = entry_in[`PAGE_SIZE_POS];
        rsvd_bad = (|entry_in[`RSVD_HI_POS:`HOST_ADDR_W])
                   || (|entry_in[`RSVD_MID_HI_POS:`RSVD_MID_LO_POS]);
        ext_track = ctl_bit(ctrl_q, `CTRL_TRACK_POS)
                    && ctl_bit(ctrl_q, `CTRL_SUPP_POS);
        // reserved layout only applies once known to be a page
        if (!present) begin
            outcome = OUT_NOTPRS;
        end else if (!page_map) begin
            outcome = OUT_DIR;
        end else if (rsvd_bad) begin
            outcome = OUT_RSVD;
        end else begin
            outcome = OUT_OK;
        end
        ok  = (outcome == OUT_OK) && !deny;
        upd = entry_in;
        if (ok) begin
            upd[`ACCESSED_POS] = 1'b1;
            if (ext_track) begin
                upd[`EXT_ACC_POS] = 1'b1;
            end
            if (req_write_in) begin
                upd[`DIRTY_POS] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            done_out      <= 1'b0;
            granted_out   <= 1'b0;
            fault_out     <= 1'b0;
            perm_deny_out <= 1'b0;
            is_dir_out    <= 1'b0;
            frame_out     <= '0;
            frame_gpa_out <= 1'b0;
            mtype_out     <= `MTYPE_DEFAULT;
            global_out    <= 1'b0;
            entry_upd_out <= '0;
            writeback_out <= 1'b0;
        end else begin
            done_out <= req_valid_in;
            if (req_valid_in) begin
                granted_out   <= ok;
                fault_out     <= (outcome == OUT_NOTPRS) || (outcome == OUT_RSVD);
                perm_deny_out <= (outcome == OUT_OK) && deny;
                is_dir_out    <= (outcome == OUT_DIR);
                frame_out     <= {entry_in[`HOST_ADDR_W-1:`FRAME_LO_POS],
                                  {`FRAME_LO_POS{1'b0}}};
                frame_gpa_out <= ctl_bit(ctrl_q, `CTRL_NEST_POS);
                mtype_out     <= mtype;
                global_out    <= ctl_bit(ctrl_q, `CTRL_GLOB_POS)
                                 && entry_in[`GLOBAL_POS];
                entry_upd_out <= upd;
                writeback_out <= ok && (upd != entry_in);
            end else begin
                writeback_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // status tracking
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            last_q  <= OUT_OK;
            count_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!req_valid_in) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (req_valid_in) begin
                last_q <= outcome;
                if (ok) begin
                    count_q <= count_q + `CNT_ONE;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= `CTRL_RESET;
        end else if (reg_write_in && reg_addr_in == `REG_CTRL) begin
            ctrl_q <= reg_wdata_in[`CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    // data stand one cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= `ZERO32;
        end else if (reg_read_in) begin
            unique case (reg_addr_in)
                `REG_CTRL:   reg_rdata_out <= {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_q};
                `REG_STATUS: reg_rdata_out <= {{(`DATA_W-6){1'b0}}, state_q, last_q};
                `REG_COUNT:  reg_rdata_out <= {{(`DATA_W-`CNT_W){1'b0}}, count_q};
                default:     reg_rdata_out <= `ZERO32;
            endcase
        end else begin
            reg_rdata_out <= `ZERO32;
        end
    end
endmodule : gpage_decode

// ### verif/gpage_decode_sva.sv
/*
 * assertions on the 1-gbyte entry decoder: outcomes, refusals, fields and timing.
 * assumes: bound into gpage_decode; mirrors the control word from its writes.
 */
`timescale 1ns/10ps
`include "gpage_params.svh"

module gpage_decode_chk (
    // same names, widths and meanings as the decoder's ports
    input wire logic                clk_in,
    input wire logic                reset_in,
    input wire logic                req_valid_in,
    input wire logic [`ENTRY_W-1:0] entry_in,
    input wire logic                req_user_in,
    input wire logic                req_write_in,
    input wire logic                req_exec_in,
    input wire logic [`ADDR_W-1:0]  reg_addr_in,
    input wire logic [`DATA_W-1:0]  reg_wdata_in,
    input wire logic                reg_write_in,
    input wire logic                reg_read_in,
    input wire logic [`DATA_W-1:0]  reg_rdata_out,
    input wire logic                done_out,
    input wire logic                granted_out,
    input wire logic                fault_out,
    input wire logic                perm_deny_out,
    input wire logic                is_dir_out,
    input wire gpage_pkg::haddr_t   frame_out,
    input wire logic                frame_gpa_out,
    input wire gpage_pkg::mtype_t   mtype_out,
    input wire logic                global_out,
    input wire logic [`ENTRY_W-1:0] entry_upd_out,
    input wire logic                writeback_out
);
    import gpage_pkg::*;
    // ------------------------------------------------------------------
    // mirrors of the control word and of the last request
    // ------------------------------------------------------------------
    logic [`CTRL_W-1:0]  ctl_q;  // control register copy
    logic [`CTRL_W-1:0]  cs_q;   // control seen by the last request
    logic [`ENTRY_W-1:0] ent_q;  // last entry taken
    logic                wr_q;   // last request sought write
    logic                rsvd;   // reserved bits nonzero
    assign rsvd = (|entry_in[51:46]) | (|entry_in[29:13]);
    // control copy follows writes to the control address
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_q <= `CTRL_RESET;
        end else if (reg_write_in && reg_addr_in == `REG_CTRL) begin
            ctl_q <= reg_wdata_in[`CTRL_W-1:0];
        end
    end
    // capture of what each request carried, for checks one cycle later
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cs_q <= `CTRL_RESET;
            ent_q <= '0;
            wr_q <= 1'b0;
        end else if (req_valid_in) begin
            cs_q <= ctl_q;
            ent_q <= entry_in;
            wr_q <= req_write_in;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_page_req;
        req_valid_in && entry_in[0] && entry_in[7] && !rsvd;
    endsequence
    sequence s_grant_done;
        done_out && granted_out;
    endsequence
    a_done_timing: assert property (req_valid_in |=> done_out)
        else $error("no result one cycle after request");
    a_no_spurious: assert property (!req_valid_in |=> !done_out && !writeback_out)
        else $error("result pulse without request");
    a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == `ZERO32)
        else $error("read data outside read slot");
    a_not_present: assert property (req_valid_in && !entry_in[0] |=> fault_out && !granted_out)
        else $error("missing entry not faulted");
    a_dir_entry: assert property (req_valid_in && entry_in[0] && !entry_in[7]
        |=> is_dir_out && !granted_out && !fault_out)
        else $error("directory entry misread");
    a_rsvd_fault: assert property (req_valid_in && entry_in[0] && entry_in[7] && rsvd
        |=> fault_out && !granted_out)
        else $error("reserved bits not faulted");
    a_exec_deny: assert property (s_page_req ##0 (req_exec_in && entry_in[63] && ctl_q[0])
        |=> perm_deny_out && !granted_out)
        else $error("execute not refused");
    a_user_deny: assert property (s_page_req ##0 (req_user_in && !entry_in[2])
        |=> perm_deny_out && !granted_out)
        else $error("user access not refused");
    a_write_deny: assert property (s_page_req ##0 (req_write_in && !entry_in[1]
        && (req_user_in || ctl_q[3])) |=> perm_deny_out && !granted_out)
        else $error("write not refused");
    a_frame_base: assert property (s_page_req |=> frame_out == {ent_q[45:30], 30'h0000_0000}
        && frame_gpa_out == cs_q[1])
        else $error("frame base wrong");
    a_mem_type: assert property (s_grant_done
        |-> mtype_out == (cs_q[6] ? {ent_q[12], ent_q[4], ent_q[3]} : 3'h0))
        else $error("memory type wrong");
    a_global_mark: assert property (s_grant_done |-> global_out == (cs_q[2] & ent_q[8]))
        else $error("global mark wrong");
    a_flag_update: assert property (s_grant_done |-> entry_upd_out == (ent_q
        | 64'h0000_0000_0000_0020 | {57'h0, wr_q, 6'h0} | {53'h0, cs_q[4] & cs_q[5], 10'h0}))
        else $error("flag update wrong");
    a_store_strobe: assert property (done_out
        |-> writeback_out == (granted_out && entry_upd_out != ent_q))
        else $error("store strobe wrong");
endmodule : gpage_decode_chk

bind gpage_decode gpage_decode_chk i_gpage_decode_chk (.*);

// ### verif/pte_source.sv
/*
 * far-side model: request source that presents fetched entries to the decoder.
 * assumes: driven by task calls from the bench; one request per call.
 */
`timescale 1ns/10ps
`include "gpage_params.svh"

module pte_source (
    input  wire logic                clk_in,         // decoder clock
    output logic                     req_valid_out,  // request strobe
    output logic [`ENTRY_W-1:0]      entry_out,      // entry word
    output logic                     user_out,       // user privilege
    output logic                     write_out,      // write request
    output logic                     exec_out        // execute request
);
    // idle at time zero
    initial begin
        req_valid_out = 1'b0;
        entry_out = '0;
        user_out = 1'b0;
        write_out = 1'b0;
        exec_out = 1'b0;
    end
    // one request after gap + 1 idle cycles; released lines show the inverse, never stale data
    task automatic issue(input logic [`ENTRY_W-1:0] e, input logic u, w, x, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        entry_out <= e;
        user_out <= u;
        write_out <= w;
        exec_out <= x;
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        entry_out <= ~e;
        user_out <= ~u;
        write_out <= ~w;
        exec_out <= ~x;
    endtask : issue
endmodule : pte_source

// ### verif/gpage_decode_tb_top.sv
/*
 * bench for the 1-gbyte entry decoder: registers, every entry class and request kind.
 * assumes: pte_source presents entries; the checker binds itself to the decoder.
 */
`timescale 1ns/10ps
`include "gpage_params.svh"

module gpage_decode_tb_top;
    import gpage_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic clk_in, reset_in, req_valid_in, req_user_in, req_write_in, req_exec_in;
    logic [`ENTRY_W-1:0] entry_in, entry_upd_out;
    logic [`ADDR_W-1:0]  reg_addr_in;
    logic [`DATA_W-1:0]  reg_wdata_in, reg_rdata_out;
    logic reg_write_in, reg_read_in, done_out, granted_out, fault_out, perm_deny_out;
    logic is_dir_out, frame_gpa_out, global_out, writeback_out;
    haddr_t frame_out;
    mtype_t mtype_out;
    logic [`CTRL_W-1:0] ctl;   // control word last written
    int num_errors, total_checks, cnt;
    logic [`ENTRY_W-1:0] ents [9] = '{64'h0000_3FFF_C000_1187, 64'h8000_2AAA_C000_0099,
        64'h0000_0000_4000_0006, 64'h0000_0000_4000_0007, 64'h0008_0000_4000_0087,
        64'h0000_0000_4000_2087, 64'h7FF0_3FFF_C000_1B87, 64'h0000_4000_4000_0087,
        64'h0000_3FFF_C000_15E7};
    logic [`CTRL_W-1:0] ctls [5] = '{7'h00, 7'h7F, 7'h09, 7'h36, 7'h50};
    // ------------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------------
    // every bench signal carries the name of the decoder port that it meets
    gpage_decode i_gpage_decode (.*);
    pte_source i_pte_source (.clk_in(clk_in), .req_valid_out(req_valid_in),
        .entry_out(entry_in), .user_out(req_user_in), .write_out(req_write_in),
        .exec_out(req_exec_in));
    // ------------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // the whole run needs about 1,100 cycles
    initial begin
        repeat (6000) @(posedge clk_in);
        num_errors++;
        complete_run();
    end
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic reg_wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask : reg_wr
    // read data is looked at in the one cycle after the strobe
    task automatic reg_rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] m, exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1;
        chk("read data", reg_rdata_out & m, exp);
    endtask : reg_rd
    // one request; expected outcome worked out from the entry, request and control word
    task automatic run(input logic [63:0] e, input logic u, w, x, input int gap);
        logic rs, f, d, pd, g;
        logic [63:0] upd;
        rs = (|e[51:46]) | (|e[29:13]);
        f = !e[0] | (e[7] & rs);
        d = e[0] & !e[7];
        pd = !f & !d & ((u & !e[2]) | (w & !e[1] & (u | ctl[3])) | (x & e[63] & ctl[0]));
        g = !f & !d & !pd;
        upd = e | 64'h0000_0000_0000_0020 | {57'h0, w, 6'h0} | {53'h0, ctl[4] & ctl[5], 10'h0};
        i_pte_source.issue(e, u, w, x, gap);
        #1;
        chk("done", done_out, 1'b1);
        chk("fault", fault_out, f);
        chk("directory", is_dir_out, d);
        chk("deny", perm_deny_out, pd);
        chk("granted", granted_out, g);
        if (g) begin
            cnt++;
            chk("frame", frame_out, {e[45:30], 30'h0000_0000});
            chk("guest frame", frame_gpa_out, ctl[1]);
            chk("mem type", mtype_out, ctl[6] ? {e[12], e[4], e[3]} : 3'h0);
            chk("global", global_out, ctl[2] & e[8]);
            chk("updated entry", entry_upd_out, upd);
            chk("store", writeback_out, upd != e);
        end
    endtask : run
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        reset_in = 1'b1;
        reg_addr_in = '0;
        reg_wdata_in = '0;
        reg_write_in = 1'b0;
        reg_read_in = 1'b0;
        num_errors = 0;
        total_checks = 0;
        cnt = 0;
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        // reset values, access kinds and an unmapped address
        reg_rd(`REG_CTRL, 32'hFFFF_FFFF, `ZERO32);
        reg_wr(`REG_CTRL, 32'hFFFF_FFFF);
        reg_rd(`REG_CTRL, 32'hFFFF_FFFF, 32'h0000_007F);
        reg_wr(`REG_COUNT, 32'h0000_1234);
        reg_rd(`REG_COUNT, 32'hFFFF_FFFF, `ZERO32);
        reg_rd(4'hC, 32'hFFFF_FFFF, `ZERO32);
        // every entry class under each control word and every request kind
        foreach (ctls[c]) begin
            ctl = ctls[c];
            reg_wr(`REG_CTRL, {25'h0, ctl});
            foreach (ents[i]) begin
                for (int m = 0; m < 8; m++) begin
                    run(ents[i], m[2], m[1], m[0], (i + m) % 3);
                end
            end
        end
        // outcome class of the last request and the granted count
        run(ents[4], 1'b0, 1'b0, 1'b0, 0);
        reg_rd(`REG_STATUS, 32'h0000_000F, 32'h0000_0008);
        reg_rd(`REG_COUNT, 32'hFFFF_FFFF, {16'h0, cnt[15:0]});
        complete_run();
    end
endmodule : gpage_decode_tb_top
